/* watchdog_and_reset_control.sv */
// Watchdog timer, keyed reset control, reset-cause flags and halt wake-up.
// Assumes an APB master, a core that reports halt and clear-watchdog
// execution as pulses, and a low-speed RC clock sampled as a level.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "wdt_rst_defs.svh"

module watchdog_and_reset_control #(
   parameter int unsigned POR_DELAY_CYCLES = `POR_DELAY_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        low_speed_internal_osc_clk,
   input  wire logic        halt_exec,
   input  wire logic        clear_watchdog_instruction_exec,
   input  wire logic [7:0]  porta_in,
   input  wire logic [7:0]  irq_req,
   input  wire logic [7:0]  irq_enable,
   input  wire logic        stack_full,
   input  wire logic        lvr_event,
   input  wire logic        lv_key_event,
   output logic             sys_reset_n,
   output logic             port_preset,
   output logic             pc_sp_clear,
   output logic             wake_resume,
   output logic             wake_vector,
   output logic             cpu_halted
);

   wdt_rst_pkg::wdt_state_t state_q;
   logic [7:0]              wdt_ctrl_q;
   logic [7:0]              rst_key_q;
   logic [7:0]              wake_en_q;
   logic [3:0]              flags_q;
   logic                    to_q;
   logic                    pdf_q;
   logic [`POR_CNT_W-1:0]   por_cnt_q;
   logic [2:0]              rst_cnt_q;
   logic                    low_speed_internal_osc_q;
   logic                    tick;
   logic [7:0]              porta_q;
   logic [7:0]              irq_armed_q;
   logic [1:0]              key_bad;
   logic [1:0]              key_cnt_q [2];
   logic [1:0]              key_fire;
   logic [17:0]             wdt_cnt;
   logic                    ovf;
   logic                    live;
   logic                    run_st;
   logic                    halt_st;
   logic                    halt_go;
   logic                    clr_go;
   logic                    wdt_on;
   logic                    wdt_clr;
   logic                    dev_rst_req;
   logic [7:0]              irq_hit;
   logic                    wake_pin;
   logic                    wake_irq;
   logic                    irq_vec_ok;
   logic                    wr_en;
   logic [31:0]             prdata_q;
   logic                    pslverr_q;
   logic [3:0]              flag_set;
   logic [3:0]              flag_keep;

   // Write strobe for one register offset
   function automatic logic wr_hit(input logic [11:0] ofs);
      return wr_en && (paddr == ofs);
   endfunction

   // State decodes
   assign run_st  = (state_q == wdt_rst_pkg::ST_RUN);
   assign halt_st = (state_q == wdt_rst_pkg::ST_HALT);
   assign live    = run_st || halt_st;
   assign halt_go = run_st && halt_exec;
   assign clr_go  = run_st && clear_watchdog_instruction_exec;

   // Low-speed RC edge; input already synchronous to pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_speed_internal_osc_q <= 1'b0;
      end else begin
         low_speed_internal_osc_q <= low_speed_internal_osc_clk;
      end
   end
   assign tick = low_speed_internal_osc_clk && !low_speed_internal_osc_q;

   // APB: zero wait states, read data captured in the setup cycle
   assign wr_en   = psel && penable && pwrite;
   assign pready  = psel && penable;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q && psel && penable;

   // Read mux; unused upper bits read zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0;
         pslverr_q <= 1'b0;
      end else if (psel && !penable) begin
         pslverr_q <= 1'b0;
         case (paddr)
            `OFS_WDT_CTRL:  prdata_q <= {24'h0, wdt_ctrl_q};
            `OFS_RST_FLAGS: prdata_q <= {28'h0, flags_q};
            `OFS_RST_KEY:   prdata_q <= {24'h0, rst_key_q};
            `OFS_STATUS:    prdata_q <= {29'h0, halt_st, pdf_q, to_q};
            `OFS_WAKE_EN:   prdata_q <= {24'h0, wake_en_q};
            default: begin
               prdata_q  <= 32'h0;
               pslverr_q <= 1'b1;
            end
         endcase
      end
   end

   // watchdog key power-on value
   // Reloaded during any device reset so a bad key cannot persist
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_ctrl_q <= `WDT_CTRL_POR;
      end else if (state_q == wdt_rst_pkg::ST_RST) begin
         wdt_ctrl_q <= `WDT_CTRL_POR;
      end else if (wr_hit(`OFS_WDT_CTRL)) begin
         wdt_ctrl_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_key_q <= `RST_KEY_POR;
      end else if (state_q == wdt_rst_pkg::ST_RST) begin
         rst_key_q <= `RST_KEY_POR;
      end else if (wr_hit(`OFS_RST_KEY)) begin
         rst_key_q <= pwdata[7:0];
      end
   end

   // Port A wake enables, cleared by any device reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_en_q <= `WAKE_EN_POR;
      end else if (state_q == wdt_rst_pkg::ST_RST) begin
         wake_en_q <= `WAKE_EN_POR;
      end else if (wr_hit(`OFS_WAKE_EN)) begin
         wake_en_q <= pwdata[7:0];
      end
   end

   assign key_bad[0] = live && !wdt_rst_pkg::wdt_key_valid(
                          wdt_ctrl_q[`WDT_KEY_HI:`WDT_KEY_LO]);
   assign key_bad[1] = live && !wdt_rst_pkg::rst_key_valid(rst_key_q);

   // Third RC edge after a bad key lands 2 to 3 RC periods later
   for (genvar gi = 0; gi < 2; gi++) begin : g_key
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            key_cnt_q[gi] <= 2'h0;
         end else if (!key_bad[gi]) begin
            key_cnt_q[gi] <= 2'h0;
         end else if (tick) begin
            key_cnt_q[gi] <= key_cnt_q[gi] + 2'h1;
         end
      end
      assign key_fire[gi] = key_bad[gi] && tick &&
                            (key_cnt_q[gi] == 2'(`KEY_RST_TICKS - 1));
   end

   // flags: hardware sets, software writes 0 to clear
   // Set wins over a clear in the same cycle; writing 1 never sets
   assign flag_set  = {key_fire[1], lvr_event, lv_key_event, key_fire[0]};
   assign flag_keep = wr_hit(`OFS_RST_FLAGS) ? pwdata[3:0] : 4'hf;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= 4'h0;
      end else begin
         flags_q <= (flags_q & flag_keep) | flag_set;
      end
   end

   assign wdt_on  = live && (wdt_ctrl_q[`WDT_KEY_HI:`WDT_KEY_LO] == `WDT_KEY_ON);
   // clear sources; key reset clears via the reset state
   assign wdt_clr = halt_go || clr_go || !live;

   wdt_prescaler u_prescaler (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick),
      .enable  (wdt_on),
      .clear   (wdt_clr),
      .sel     (wdt_ctrl_q[`WDT_SEL_HI:`WDT_SEL_LO]),
      .count   (wdt_cnt),
      .overflow(ovf)
   );

   // power-down and time-out flags
   // Overflow wins over the halt clear of time-out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         to_q  <= 1'b0;
         pdf_q <= 1'b0;
      end else begin
         if (ovf && live) begin
            to_q <= 1'b1;
         end else if (halt_go) begin
            to_q <= 1'b0;
         end
         if (halt_go) begin
            pdf_q <= 1'b1;
         end else if (clr_go) begin
            pdf_q <= 1'b0;
         end
      end
   end

   // Wake sources while halted
   // arm only interrupts not flagged at halt entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_armed_q <= 8'h00;
      end else if (halt_go) begin
         irq_armed_q <= ~irq_req;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         porta_q <= `PORTA_IDLE;
      end else begin
         porta_q <= porta_in;
      end
   end
   assign wake_pin   = halt_st && |(porta_q & ~porta_in & wake_en_q);
   assign irq_hit    = irq_req & irq_armed_q;
   assign wake_irq   = halt_st && |irq_hit;
   assign irq_vec_ok = |(irq_hit & irq_enable) && !stack_full;

   // Wake and clear pulses; key reset outranks every wake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_sp_clear <= 1'b0;
         wake_vector <= 1'b0;
         wake_resume <= 1'b0;
      end else begin
         pc_sp_clear <= 1'b0;
         wake_vector <= 1'b0;
         wake_resume <= 1'b0;
         if (halt_st && !(|key_fire)) begin
            if (ovf) begin
               // halt overflow clears PC and SP
               pc_sp_clear <= 1'b1;
            end else if (wake_irq && irq_vec_ok) begin
               wake_vector <= 1'b1;
            end else if (wake_pin || wake_irq) begin
               wake_resume <= 1'b1;
            end
         end
      end
   end

   // running overflow or bad key resets device
   assign dev_rst_req = (|key_fire) || (ovf && run_st);

   // Reset sequencer and run/halt state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= wdt_rst_pkg::ST_POR;
      end else begin
         unique case (state_q)
            wdt_rst_pkg::ST_POR: begin
               if (por_cnt_q == `POR_CNT_W'(POR_DELAY_CYCLES - 1)) begin
                  state_q <= wdt_rst_pkg::ST_RUN;
               end
            end
            wdt_rst_pkg::ST_RUN: begin
               if (dev_rst_req) begin
                  state_q <= wdt_rst_pkg::ST_RST;
               end else if (halt_exec) begin
                  state_q <= wdt_rst_pkg::ST_HALT;
               end
            end
            wdt_rst_pkg::ST_HALT: begin
               if (|key_fire) begin
                  state_q <= wdt_rst_pkg::ST_RST;
               end else if (ovf || wake_pin || wake_irq) begin
                  state_q <= wdt_rst_pkg::ST_RUN;
               end
            end
            wdt_rst_pkg::ST_RST: begin
               if (rst_cnt_q == 3'(`RST_PULSE_CYCLES - 1)) begin
                  state_q <= wdt_rst_pkg::ST_RUN;
               end
            end
         endcase
      end
   end

   // Power-on and reset pulse counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_cnt_q <= '0;
      end else if (state_q == wdt_rst_pkg::ST_POR) begin
         por_cnt_q <= por_cnt_q + `POR_CNT_W'(1);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_cnt_q <= 3'h0;
      end else if (state_q == wdt_rst_pkg::ST_RST) begin
         rst_cnt_q <= rst_cnt_q + 3'h1;
      end else begin
         rst_cnt_q <= 3'h0;
      end
   end

   // ports preset high and core reset in power-on
   assign port_preset = (state_q == wdt_rst_pkg::ST_POR);
   assign sys_reset_n = live;
   assign cpu_halted  = halt_st;

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_rst_pulse;
      !sys_reset_n [*4] ##1 sys_reset_n;
   endsequence

   property p_key_fire_wdt;
      key_fire[0] |-> key_cnt_q[0] == 2'h2 ##1 flags_q[0] && !sys_reset_n;
   endproperty
   a_key_fire_wdt: assert property (p_key_fire_wdt)
      else $error("watchdog key reset timing wrong");

   property p_wdt_flag_hold;
      $fell(flags_q[0]) |-> $past(wr_en) && $past(paddr) == `OFS_RST_FLAGS
                            && !$past(pwdata[0]) && !$past(key_fire[0]);
   endproperty
   a_wdt_flag_hold: assert property (p_wdt_flag_hold)
      else $error("watchdog key flag cleared without software");

   property p_ctrl_key_reset;
      key_fire[1] |=> flags_q[3] ##0 s_rst_pulse;
   endproperty
   a_ctrl_key_reset: assert property (p_ctrl_key_reset)
      else $error("reset key did not reset and flag");

   property p_ovf_run;
      ovf && run_st |=> to_q ##0 s_rst_pulse;
   endproperty
   a_ovf_run: assert property (p_ovf_run)
      else $error("running overflow did not reset device");

   property p_ovf_halt;
      ovf && halt_st && !(|key_fire) |=> pc_sp_clear && to_q && sys_reset_n;
   endproperty
   a_ovf_halt: assert property (p_ovf_halt)
      else $error("halt overflow did not clear pc and sp");

   property p_halt_entry;
      halt_go |=> pdf_q && !to_q && halt_st && wdt_cnt == 18'h00000;
   endproperty
   a_halt_entry: assert property (p_halt_entry)
      else $error("halt entry flags or count wrong");

   property p_clear_watchdog_instruction;
      clr_go |=> wdt_cnt == 18'h00000 && !pdf_q;
   endproperty
   a_clear_watchdog_instruction: assert property (p_clear_watchdog_instruction)
      else $error("clear watchdog did not clear count");

   property p_pin_wake;
      wake_pin && !ovf && !wake_irq && !(|key_fire) |=> wake_resume && run_st;
   endproperty
   a_pin_wake: assert property (p_pin_wake)
      else $error("port wake did not resume");

   property p_irq_vector;
      wake_irq && irq_vec_ok && !ovf && !(|key_fire) |=> wake_vector && !wake_resume;
   endproperty
   a_irq_vector: assert property (p_irq_vector)
      else $error("enabled interrupt wake not vectored");

   property p_disabled_off;
      halt_st && wdt_ctrl_q[7:3] == `WDT_KEY_OFF |-> !ovf ##1 $stable(wdt_cnt);
   endproperty
   a_disabled_off: assert property (p_disabled_off)
      else $error("disabled watchdog still counting");

endmodule

/* wdt_rst_defs.svh */
// Constants for the watchdog and reset control block.
// Assumes pclk at 100 MHz and APB byte addresses on paddr.
`ifndef WDT_RST_DEFS_SVH
`define WDT_RST_DEFS_SVH

// Register byte offsets
`define OFS_WDT_CTRL      12'h000
`define OFS_RST_FLAGS     12'h004
`define OFS_RST_KEY       12'h008
`define OFS_STATUS        12'h00c
`define OFS_WAKE_EN       12'h010

// Reset values
`define WDT_CTRL_POR      8'h53
`define RST_KEY_POR       8'h55
`define WAKE_EN_POR       8'h00
`define PORTA_IDLE        8'hff

// Key codes
`define WDT_KEY_OFF       5'h15
`define WDT_KEY_ON        5'h0a
`define RST_KEY_A         8'h55
`define RST_KEY_B         8'haa

// Field positions
`define WDT_KEY_HI        7
`define WDT_KEY_LO        3
`define WDT_SEL_HI        2
`define WDT_SEL_LO        0
`define FLG_CTRL_KEY      3
`define FLG_LVR           2
`define FLG_LV_KEY        1
`define FLG_WDT_KEY       0
`define STS_TO            0
`define STS_PDF           1
`define STS_HALTED        2

// Overflow points, last count before wrap
`define WDT_LIM_0         18'h000ff
`define WDT_LIM_1         18'h003ff
`define WDT_LIM_2         18'h00fff
`define WDT_LIM_3         18'h03fff
`define WDT_LIM_4         18'h07fff
`define WDT_LIM_5         18'h0ffff
`define WDT_LIM_6         18'h1ffff
`define WDT_LIM_7         18'h3ffff

// Timing
`define CLK_PERIOD_NS     10
`define NS_PER_MS         1000000
`define POR_DELAY_MS      50
`define POR_DELAY_CYCLES  ((`POR_DELAY_MS * `NS_PER_MS) / `CLK_PERIOD_NS)
`define POR_CNT_W         23
`define KEY_RST_TICKS     3
`define RST_PULSE_CYCLES  4

`endif

/* wdt_rst_pkg.sv */
// Types and decode helpers shared by the watchdog files.
// Assumes the constants header is on the include path.
`include "wdt_rst_defs.svh"

package wdt_rst_pkg;

   // Block state, Gray along POR -> RUN -> HALT
   typedef enum logic [1:0] {
      ST_POR  = 2'b00,
      ST_RUN  = 2'b01,
      ST_HALT = 2'b11,
      ST_RST  = 2'b10
   } wdt_state_t;

   // Watchdog key holds one of its two legal codes
   function automatic logic wdt_key_valid(input logic [4:0] key);
      return (key == `WDT_KEY_ON) || (key == `WDT_KEY_OFF);
   endfunction

   // Reset-control key holds one of its two legal codes
   function automatic logic rst_key_valid(input logic [7:0] key);
      return (key == `RST_KEY_A) || (key == `RST_KEY_B);
   endfunction

   // Last count before overflow for each period select
   function automatic logic [17:0] wdt_limit(input logic [2:0] sel);
      logic [17:0] lim;
      lim = `WDT_LIM_7;
      case (sel)
         3'h0: lim = `WDT_LIM_0;
         3'h1: lim = `WDT_LIM_1;
         3'h2: lim = `WDT_LIM_2;
         3'h3: lim = `WDT_LIM_3;
         3'h4: lim = `WDT_LIM_4;
         3'h5: lim = `WDT_LIM_5;
         3'h6: lim = `WDT_LIM_6;
         3'h7: lim = `WDT_LIM_7;
         default: lim = `WDT_LIM_7;
      endcase
      return lim;
   endfunction

endpackage

/* wdt_prescaler.sv */
// Watchdog counter on low-speed RC ticks with selectable overflow tap.
// Assumes tick is a one-cycle pulse per low-speed RC period.
`timescale 1ns/10ps

module wdt_prescaler (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        tick,
   input  wire logic        enable,
   input  wire logic        clear,
   input  wire logic [2:0]  sel,
   output logic      [17:0] count,
   output logic             overflow
);

   logic [17:0] limit;
   logic        at_lim;

   // Tap decode; >= covers a select lowered mid-count
   assign limit  = wdt_rst_pkg::wdt_limit(sel);
   assign at_lim = (count >= limit);

   // Counter wraps on overflow so each overflow fires once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
      end else if (clear) begin
         count <= '0;
      end else if (enable && tick) begin
         count <= at_lim ? '0 : count + 18'h00001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow <= 1'b0;
      end else begin
         overflow <= !clear && enable && tick && at_lim;
      end
   end

endmodule

/* tb.sv */
// Self-checking bench for the watchdog and reset control block.
// Assumes the constants header and package are compiled before this file.
`timescale 1ns/10ps
`include "wdt_rst_defs.svh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin miscompares++; \
   $display("unexpected %s exp %h got %h", nm, ex, gt); end end

module tb;
   int          miscompares = 0;
   int          check_count = 0;
   int          cycles      = 0;
   logic        pclk        = 1'b0;
   logic        presetn     = 1'b0;
   logic [11:0] paddr       = 12'h000;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [31:0] pwdata      = 32'h0;
   logic        low_speed_internal_osc_clk    = 1'b0;
   logic        halt_exec   = 1'b0;
   logic        clear_watchdog_instruction     = 1'b0;
   logic [7:0]  porta_in    = 8'hff;
   logic [7:0]  irq_req     = 8'h00;
   logic [7:0]  irq_enable  = 8'h00;
   logic        stack_full  = 1'b0;
   logic [31:0] prdata, rdata;
   logic        pready, pslverr, rerr, sys_reset_n, port_preset;
   logic        pc_sp_clear, wake_resume, wake_vector, cpu_halted;
   bit          seen;

   // Short power-on delay keeps the run brief
   watchdog_and_reset_control #(.POR_DELAY_CYCLES(8)) DUT (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .low_speed_internal_osc_clk(low_speed_internal_osc_clk), .halt_exec(halt_exec),
      .clear_watchdog_instruction_exec(clear_watchdog_instruction), .porta_in(porta_in), .irq_req(irq_req),
      .irq_enable(irq_enable), .stack_full(stack_full), .lvr_event(1'b0),
      .lv_key_event(1'b0), .sys_reset_n(sys_reset_n), .port_preset(port_preset),
      .pc_sp_clear(pc_sp_clear), .wake_resume(wake_resume),
      .wake_vector(wake_vector), .cpu_halted(cpu_halted));

   always #5 pclk = ~pclk;

   // Hang guard, well above the expected run length
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         print_verdict();
      end
   end

   task print_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // One APB transfer; read data and error taken at the pready edge
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // One-cycle core pulse: halt when h, else clear-watchdog
   task automatic pulse(input bit h);
      @(posedge pclk);
      halt_exec <= h;
      clear_watchdog_instruction <= !h;
      @(posedge pclk);
      halt_exec <= 1'b0;
      clear_watchdog_instruction <= 1'b0;
   endtask

   // Returns at the edge that raises the last RC tick
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge pclk);
         low_speed_internal_osc_clk <= 1'b0;
         @(posedge pclk);
         @(posedge pclk);
         low_speed_internal_osc_clk <= 1'b1;
      end
   endtask

   // Watches one output for n cycles, sampled after the edge settles
   task automatic wait_for(input int w, input int n);
      seen = 1'b0;
      repeat (n) begin
         @(posedge pclk);
         #1;
         if ((w == 0 && sys_reset_n === 1'b0) || (w == 1 && pc_sp_clear === 1'b1) ||
             (w == 2 && wake_resume === 1'b1) || (w == 3 && wake_vector === 1'b1) ||
             (w == 4 && sys_reset_n === 1'b1))
            seen = 1'b1;
      end
   endtask

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      `CHK("port_preset", 1'b1, port_preset)
      wait_for(4, 14);
      `CHK("por release", 1'b1, seen)
      `CHK("port_preset off", 1'b0, port_preset)
      apb(`OFS_WDT_CTRL, 1'b0, 32'h0);
      `CHK("ctrl por", 32'h53, rdata)
      apb(`OFS_RST_KEY, 1'b0, 32'h0);
      `CHK("key por", 32'h55, rdata)
      apb(`OFS_RST_FLAGS, 1'b0, 32'h0);
      `CHK("flags por", 32'h0, rdata & 32'hfffffffb)
      apb(12'h020, 1'b0, 32'h0);
      `CHK("unmapped err", 1'b1, rerr)
      // Clear-watchdog twice inside the period stops any overflow
      apb(`OFS_WDT_CTRL, 1'b1, 32'h50);
      pulse(0);
      ticks(200);
      pulse(0);
      ticks(200);
      wait_for(0, 12);
      `CHK("clr holds off", 1'b0, seen)
      // Overflow exactly at 2^8 and 2^10 ticks
      for (int s = 0; s < 2; s++) begin
         apb(`OFS_WDT_CTRL, 1'b1, {24'h0, `WDT_KEY_ON, 3'(s)});
         pulse(0);
         ticks((256 << (2 * s)) - 1);
         wait_for(0, 12);
         `CHK("early ovf", 1'b0, seen)
         ticks(1);
         wait_for(0, 12);
         `CHK("ovf reset", 1'b1, seen)
         wait_for(4, 12);
         apb(`OFS_STATUS, 1'b0, 32'h0);
         `CHK("timeout set", 1'b1, rdata[0])
         apb(`OFS_WDT_CTRL, 1'b0, 32'h0);
         `CHK("ctrl reload", 32'h53, rdata)
      end
      apb(`OFS_WDT_CTRL, 1'b1, {24'h0, `WDT_KEY_OFF, 3'h0});
      ticks(300);
      wait_for(0, 8);
      `CHK("disabled", 1'b0, seen)
      // Bad watchdog key fires on the third tick
      apb(`OFS_WDT_CTRL, 1'b1, 32'h0);
      ticks(2);
      wait_for(0, 8);
      `CHK("key early", 1'b0, seen)
      ticks(1);
      wait_for(0, 12);
      `CHK("key reset", 1'b1, seen)
      wait_for(4, 12);
      apb(`OFS_RST_FLAGS, 1'b1, 32'hff);
      apb(`OFS_RST_FLAGS, 1'b0, 32'h0);
      `CHK("wdt key flag", 1'b1, rdata[0])
      apb(`OFS_RST_FLAGS, 1'b1, 32'h0);
      apb(`OFS_RST_FLAGS, 1'b0, 32'h0);
      `CHK("flag cleared", 1'b0, rdata[0])
      apb(`OFS_RST_KEY, 1'b1, 32'haa);
      ticks(4);
      wait_for(0, 8);
      `CHK("key aa quiet", 1'b0, seen)
      apb(`OFS_RST_KEY, 1'b1, 32'h12);
      ticks(3);
      wait_for(0, 12);
      `CHK("rst key reset", 1'b1, seen)
      wait_for(4, 12);
      apb(`OFS_RST_FLAGS, 1'b0, 32'h0);
      `CHK("ctrl key flag", 1'b1, rdata[3])
      // Halt clears the count, then overflow in halt wakes only
      apb(`OFS_WDT_CTRL, 1'b1, 32'h50);
      pulse(0);
      ticks(100);
      pulse(1);
      apb(`OFS_STATUS, 1'b0, 32'h0);
      `CHK("halt status", 3'b110, rdata[2:0])
      ticks(255);
      wait_for(1, 8);
      `CHK("halt early", 1'b0, seen)
      ticks(1);
      wait_for(1, 8);
      `CHK("pc_sp_clear", 1'b1, seen)
      `CHK("no sys reset", 1'b1, sys_reset_n)
      apb(`OFS_STATUS, 1'b0, 32'h0);
      `CHK("halt ovf flags", 3'b011, rdata[2:0])
      // Wake sources with the watchdog stopped
      apb(`OFS_WDT_CTRL, 1'b1, {24'h0, `WDT_KEY_OFF, 3'h0});
      apb(`OFS_WAKE_EN, 1'b1, 32'h01);
      pulse(1);
      @(posedge pclk);
      porta_in <= 8'hfe;
      wait_for(2, 8);
      `CHK("pin wake", 1'b1, seen)
      porta_in <= 8'hff;
      irq_enable <= 8'hff;
      irq_req <= 8'h01;
      pulse(1);
      porta_in <= 8'hfd;
      wait_for(2, 8);
      `CHK("stale irq halted", 1'b1, cpu_halted)
      irq_req <= 8'h03;
      wait_for(3, 8);
      `CHK("vector wake", 1'b1, seen)
      irq_req <= 8'h00;
      porta_in <= 8'hff;
      stack_full <= 1'b1;
      pulse(1);
      irq_req <= 8'h04;
      wait_for(2, 8);
      `CHK("stack full resume", 1'b1, seen)
      stack_full <= 1'b0;
      pulse(0);
      apb(`OFS_STATUS, 1'b0, 32'h0);
      `CHK("pdf cleared", 1'b0, rdata[1])
      print_verdict();
   end
endmodule
